//--- hw/sbo_pkg.sv
// Constants and layouts for the serial bus node options register block
// Operation
// - Bit 31 is a writable resource-manager-capable flag, kept valid by software.
// - Bit 30 is a writable cycle-master-capable flag.
// - Bit 29 is a writable isochronous-support-capable flag.
// - Bit 28 is a writable bus-manager-capable flag.
// - Bit 27 is a writable flag; one means power-management capable.
// - Bits 26 to 24 read zero and ignore writes.
// - Bits 23 to 16 hold writable cycle-master clock accuracy in ppm.
// - Bits 15 to 12 encode max block request; bytes are 2^(code+1), never below 512.
// - Block write longer than the request size may get a type-error acknowledge.
// - Hardware reset loads the 2048-byte code; software reset leaves it.
// - Register sits at offset 20h and feeds the bus information quadlet reads.
// - Bits 11 to 8 and 5 to 3 read zero and ignore writes.
// - Bits 2 to 0 read constant 010 for 100/200/400 speeds.
package sbo_pkg;

    // ========================================================================
    // Register map
    localparam int SBO_ADDR_W = 8;
    localparam logic [7:0] SBO_CTRL_OFS = 8'h00;
    localparam logic [7:0] SBO_STAT_OFS = 8'h04;
    localparam logic [7:0] SBO_OPT_OFS = 8'h20;

    // ========================================================================
    // Options register field positions
    localparam int SBO_IRMC_BIT = 31;
    localparam int SBO_CMC_BIT = 30;
    localparam int SBO_ISC_BIT = 29;
    localparam int SBO_BMC_BIT = 28;
    localparam int SBO_PMC_BIT = 27;
    localparam int SBO_ACC_LSB = 16;
    localparam int SBO_MREC_LSB = 12;
    localparam int SBO_GEN_LSB = 6;
    localparam int SBO_SPD_LSB = 0;

    // ========================================================================
    // Reset and constant values
    localparam logic [4:0] SBO_CAP_RST = 5'h00;
    localparam logic [7:0] SBO_ACC_RST = 8'h00;
    localparam logic [3:0] SBO_MREC_RST = 4'hA;
    localparam logic [3:0] SBO_MREC_MIN = 4'h8;
    localparam logic [1:0] SBO_GEN_RST = 2'h0;
    localparam logic [2:0] SBO_SPD_VAL = 3'h2;

    // ========================================================================
    // Control and status layout
    localparam int SBO_CTRL_TEEN_BIT = 0;
    localparam logic SBO_CTRL_TEEN_RST = 1'b1;
    localparam int SBO_STAT_SEEN_BIT = 16;
    localparam logic [15:0] SBO_ERRCNT_RST = 16'h0000;

    // ========================================================================
    // Bus slave phase
    typedef enum logic [1:0] {
        SBO_PH_IDLE = 2'b00,
        SBO_PH_SETUP = 2'b01,
        SBO_PH_ACCESS = 2'b11
    } sbo_phase_e;

endpackage

//--- hw/sbo_field.sv
// One software-writable field with hardware and optional software reset
`timescale 1ns/1ps
module sbo_field
    import sbo_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0,
    parameter bit SOFT_KEEP = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic wr_en,
    input wire logic [W-1:0] wr_val,
    input wire logic soft_clr,
    // Value
    output logic [W-1:0] q
);

    // ========================================================================
    // Checks
    if (W < 1) begin : g_w_chk
        $error("field width must be at least one");
    end

    logic [W-1:0] val_d;
    logic [W-1:0] val_q;

    // A write in the same cycle as a software reset wins, the later intent
    always_comb begin
        val_d = val_q;
        if (soft_clr && !SOFT_KEEP) begin
            val_d = RST;
        end
        if (wr_en) begin
            val_d = wr_val;
        end
    end

    // Storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_q <= RST;
        end else begin
            val_q <= val_d;
        end
    end

    assign q = val_q;

endmodule

//--- hw/sbo_options_reg.sv
// Serial bus node options register with APB access and link-side views
`timescale 1ns/1ps
module sbo_options_reg
    import sbo_pkg::*;
#(
    parameter int LEN_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SBO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Software reset pulse
    input wire logic soft_reset,
    // Bus information block quadlet read
    input wire logic ext_rd_req,
    output logic ext_rd_valid,
    output logic [31:0] ext_rd_data,
    // Received block write length check
    input wire logic blk_wr_req,
    input wire logic [LEN_W-1:0] blk_wr_len,
    output logic blk_wr_done,
    output logic ack_type_error
);

    // ========================================================================
    // Elaboration checks
    if (LEN_W < 1 || LEN_W > 16) begin : g_len_chk
        $error("LEN_W must be 1 to 16");
    end

    // ========================================================================
    // Declarations
    sbo_phase_e ph_q;
    sbo_phase_e ph_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic slverr_q;
    logic slverr_d;
    logic teen_q;
    logic teen_d;
    logic [15:0] errcnt_q;
    logic [15:0] errcnt_d;
    logic seen_q;
    logic seen_d;
    logic xvalid_q;
    logic xvalid_d;
    logic [31:0] xdata_q;
    logic [31:0] xdata_d;
    logic done_q;
    logic done_d;
    logic terr_q;
    logic terr_d;

    logic setup;
    logic access;
    logic hit_opt;
    logic hit_ctrl;
    logic hit_stat;
    logic mapped;
    logic wr_opt;
    logic wr_ctrl;
    logic wr_stat;
    logic [31:0] lane_mask;
    logic [31:0] opt_q;
    logic [31:0] opt_d;
    logic [31:0] opt_wv;
    logic [31:0] ctrl_rd;
    logic [31:0] stat_rd;
    logic [4:0] cap_q;
    logic [7:0] acc_q;
    logic [3:0] mrec_q;
    logic [1:0] gen_q;
    logic mrec_ok;
    logic [16:0] limit;
    logic too_long;
    logic err_evt;
    logic stat_clr;

    // ========================================================================
    // APB decode
    assign setup = psel && !penable;
    assign access = psel && penable && (ph_q == SBO_PH_SETUP); // A held enable never repeats
    assign hit_opt = (paddr == SBO_OPT_OFS);
    assign hit_ctrl = (paddr == SBO_CTRL_OFS);
    assign hit_stat = (paddr == SBO_STAT_OFS);
    assign mapped = hit_opt || hit_ctrl || hit_stat;

    // Writes land only in the access phase, so each takes effect once
    assign wr_opt = access && pwrite && hit_opt;
    assign wr_ctrl = access && pwrite && hit_ctrl;
    assign wr_stat = access && pwrite && hit_stat;

    // Byte strobes widened to a bit mask
    always_comb begin
        lane_mask = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            lane_mask[8*i +: 8] = {8{pstrb[i]}};
        end
    end

    // Phase tracker, Gray stepped along idle, setup, access
    always_comb begin
        ph_d = ph_q;
        case (ph_q)
            SBO_PH_IDLE: begin
                if (setup) begin
                    ph_d = SBO_PH_SETUP;
                end
            end
            SBO_PH_SETUP: begin
                ph_d = access ? SBO_PH_ACCESS : SBO_PH_IDLE;
            end
            SBO_PH_ACCESS: begin
                ph_d = setup ? SBO_PH_SETUP : SBO_PH_IDLE;
            end
            default: begin
                ph_d = SBO_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= SBO_PH_IDLE;
        end else begin
            ph_q <= ph_d;
        end
    end

    // ========================================================================
    // Options register fields
    // Reserved and constant bits are rebuilt on every read, never stored
    always_comb begin
        opt_q = 32'h0000_0000;
        opt_q[SBO_IRMC_BIT] = cap_q[4];
        opt_q[SBO_CMC_BIT] = cap_q[3];
        opt_q[SBO_ISC_BIT] = cap_q[2];
        opt_q[SBO_BMC_BIT] = cap_q[1];
        opt_q[SBO_PMC_BIT] = cap_q[0];
        opt_q[SBO_ACC_LSB +: 8] = acc_q;
        opt_q[SBO_MREC_LSB +: 4] = mrec_q;
        opt_q[SBO_GEN_LSB +: 2] = gen_q;
        opt_q[SBO_SPD_LSB +: 3] = SBO_SPD_VAL;
    end

    // Merge of the write data into the current value under the strobes
    assign opt_wv = (opt_q & ~lane_mask) | (pwdata & lane_mask);

    // A code under the 512-byte floor is refused; the old code stays
    assign mrec_ok = (opt_wv[SBO_MREC_LSB +: 4] >= SBO_MREC_MIN);

    // Capability flags, cleared by a software reset
    sbo_field #(
        .W(5),
        .RST(SBO_CAP_RST),
        .SOFT_KEEP(1'b0)
    ) u_cap (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_opt),
        .wr_val(opt_wv[SBO_PMC_BIT +: 5]),
        .soft_clr(soft_reset),
        .q(cap_q)
    );

    // Cycle master clock accuracy
    sbo_field #(
        .W(8),
        .RST(SBO_ACC_RST),
        .SOFT_KEEP(1'b0)
    ) u_acc (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_opt),
        .wr_val(opt_wv[SBO_ACC_LSB +: 8]),
        .soft_clr(soft_reset),
        .q(acc_q)
    );

    // Maximum request code survives a software reset
    sbo_field #(
        .W(4),
        .RST(SBO_MREC_RST),
        .SOFT_KEEP(1'b1)
    ) u_mrec (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_opt && mrec_ok),
        .wr_val(opt_wv[SBO_MREC_LSB +: 4]),
        .soft_clr(soft_reset),
        .q(mrec_q)
    );

    // Generation counter, software maintained
    sbo_field #(
        .W(2),
        .RST(SBO_GEN_RST),
        .SOFT_KEEP(1'b0)
    ) u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_opt),
        .wr_val(opt_wv[SBO_GEN_LSB +: 2]),
        .soft_clr(soft_reset),
        .q(gen_q)
    );

    // ========================================================================
    // Value the register will hold after this edge
    // Used by the external view so a write is never a cycle stale
    always_comb begin
        opt_d = opt_q;
        if (wr_opt) begin
            opt_d[SBO_PMC_BIT +: 5] = opt_wv[SBO_PMC_BIT +: 5];
            opt_d[SBO_ACC_LSB +: 8] = opt_wv[SBO_ACC_LSB +: 8];
            opt_d[SBO_GEN_LSB +: 2] = opt_wv[SBO_GEN_LSB +: 2];
            if (mrec_ok) begin
                opt_d[SBO_MREC_LSB +: 4] = opt_wv[SBO_MREC_LSB +: 4];
            end
        end else if (soft_reset) begin
            opt_d[SBO_PMC_BIT +: 5] = SBO_CAP_RST;
            opt_d[SBO_ACC_LSB +: 8] = SBO_ACC_RST;
            opt_d[SBO_GEN_LSB +: 2] = SBO_GEN_RST;
        end
    end

    // ========================================================================
    // Control and status
    assign ctrl_rd = {31'h0000_0000, teen_q};
    assign stat_rd = {15'h0000, seen_q, errcnt_q};

    // Type-error enable, byte lane 0
    always_comb begin
        teen_d = teen_q;
        if (wr_ctrl && pstrb[0]) begin
            teen_d = pwdata[SBO_CTRL_TEEN_BIT];
        end
    end

    // Error counter and sticky flag; a new error beats a clear
    assign stat_clr = wr_stat && pstrb[2] && pwdata[SBO_STAT_SEEN_BIT];
    always_comb begin
        errcnt_d = errcnt_q;
        seen_d = seen_q;
        if (stat_clr) begin
            errcnt_d = SBO_ERRCNT_RST;
            seen_d = 1'b0;
        end
        if (err_evt) begin
            seen_d = 1'b1;
            if (stat_clr) begin
                errcnt_d = 16'h0001;
            end else if (errcnt_q != 16'hFFFF) begin
                errcnt_d = errcnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            teen_q <= SBO_CTRL_TEEN_RST;
            errcnt_q <= SBO_ERRCNT_RST;
            seen_q <= 1'b0;
        end else begin
            teen_q <= teen_d;
            errcnt_q <= errcnt_d;
            seen_q <= seen_d;
        end
    end

    // ========================================================================
    // APB read data and error, captured at the setup edge
    // Zero wait states, so pready can stay high
    always_comb begin
        rdata_d = rdata_q;
        slverr_d = slverr_q;
        if (setup) begin
            slverr_d = !mapped;
            if (hit_opt) begin
                rdata_d = opt_q;
            end else if (hit_ctrl) begin
                rdata_d = ctrl_rd;
            end else if (hit_stat) begin
                rdata_d = stat_rd;
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = access && slverr_q;

    // ========================================================================
    // Bus information block view
    // The request edge samples the value after any same-cycle write
    always_comb begin
        xvalid_d = ext_rd_req;
        xdata_d = xdata_q;
        if (ext_rd_req) begin
            xdata_d = opt_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xvalid_q <= 1'b0;
            xdata_q <= 32'h0000_0000;
        end else begin
            xvalid_q <= xvalid_d;
            xdata_q <= xdata_d;
        end
    end

    assign ext_rd_valid = xvalid_q;
    assign ext_rd_data = xdata_q;

    // ========================================================================
    // Block write length check
    // Limit in bytes is two to the power of code plus one
    assign limit = 17'h0_0001 << ({1'b0, mrec_q} + 5'h01);
    assign too_long = ({{(17-LEN_W){1'b0}}, blk_wr_len} > limit);
    assign err_evt = blk_wr_req && too_long && teen_q;

    always_comb begin
        done_d = blk_wr_req;
        terr_d = err_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            terr_q <= 1'b0;
        end else begin
            done_q <= done_d;
            terr_q <= terr_d;
        end
    end

    assign blk_wr_done = done_q;
    assign ack_type_error = terr_q;

endmodule

//--- bench/sbo_props.sv
// Concurrent checks on the options register block ports
`timescale 1ns/1ps
module sbo_props
    import sbo_pkg::*;
#(
    parameter int LEN_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SBO_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Link side
    input wire logic ext_rd_req,
    input wire logic ext_rd_valid,
    input wire logic [31:0] ext_rd_data,
    input wire logic blk_wr_req,
    input wire logic [LEN_W-1:0] blk_wr_len,
    input wire logic blk_wr_done,
    input wire logic ack_type_error
);
    // ========================================================================
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_EXT_VALID:
    assert property (ext_rd_req |=> ext_rd_valid) else $error("quadlet answer missing");
    AST_EXT_HOLD:
    assert property (!ext_rd_req |=> $stable(ext_rd_data)) else $error("quadlet data moved");
    AST_EXT_RSV:
    assert property (ext_rd_valid |-> (ext_rd_data & 32'h0700_0F3F) == 32'h2)
        else $error("quadlet fixed bits wrong");
    AST_EXT_FLOOR:
    assert property (ext_rd_valid |-> ext_rd_data[15:12] >= 4'h8) else $error("request below floor");
    AST_APB_RSV:
    assert property (psel && penable && !pwrite && paddr == SBO_OPT_OFS
        |-> (prdata & 32'h0700_0F3F) == 32'h2) else $error("bus read fixed bits wrong");
    AST_OPT_MAPPED:
    assert property (psel && penable && paddr == SBO_OPT_OFS |-> !pslverr)
        else $error("options offset refused");
    AST_BLK_DONE:
    assert property (blk_wr_req |=> blk_wr_done) else $error("length check missing");
    AST_ACK_PAIR:
    assert property (ack_type_error |-> blk_wr_done && $past(blk_wr_req))
        else $error("stray type error");
    AST_SMALL_OK:
    assert property (blk_wr_req && blk_wr_len <= 512 |=> !ack_type_error)
        else $error("512 bytes refused");
endmodule

bind sbo_options_reg sbo_props #(.LEN_W(LEN_W)) sbo_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .ext_rd_req(ext_rd_req),
    .ext_rd_valid(ext_rd_valid), .ext_rd_data(ext_rd_data), .blk_wr_req(blk_wr_req),
    .blk_wr_len(blk_wr_len), .blk_wr_done(blk_wr_done), .ack_type_error(ack_type_error)
);

//--- bench/sbo_node_model.sv
// Remote node model: quadlet reads and received block write lengths
`timescale 1ns/1ps
module sbo_node_model #(
    parameter int LEN_W = 16
) (
    // Clock
    input wire logic pclk,
    // Quadlet read
    output logic ext_rd_req,
    input wire logic ext_rd_valid,
    input wire logic [31:0] ext_rd_data,
    // Block write check
    output logic blk_wr_req,
    output logic [LEN_W-1:0] blk_wr_len,
    input wire logic blk_wr_done,
    input wire logic ack_type_error
);
    // Idle; the length is inverted after use so a stale value never looks valid
    initial begin
        ext_rd_req = 1'b0;
        blk_wr_req = 1'b0;
        blk_wr_len = '1;
    end

    // Read of the second quadlet; gap makes the node slow to ask
    task automatic rd_quad(input int gap, output logic [31:0] q, output bit ok);
        int k;
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        ext_rd_req <= 1'b1;
        @(posedge pclk);
        ext_rd_req <= 1'b0;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (ext_rd_valid !== 1'b1 && k < 8);
        q = ext_rd_data;
        ok = (k < 8);
    endtask

    // Hand over a received block write length and take the verdict
    task automatic blk_wr(input logic [LEN_W-1:0] len, output logic err, output bit ok);
        int k;
        @(posedge pclk);
        blk_wr_req <= 1'b1;
        blk_wr_len <= len;
        @(posedge pclk);
        blk_wr_req <= 1'b0;
        blk_wr_len <= ~len;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (blk_wr_done !== 1'b1 && k < 8);
        err = ack_type_error;
        ok = (k < 8);
    endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the options register block
`timescale 1ns/1ps
module tb_top
    import sbo_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic soft_reset = 1'b0;
    logic [31:0] prdata, ext_rd_data, mdl;
    logic pready, pslverr, ext_rd_req, ext_rd_valid, blk_wr_req, blk_wr_done, ack_type_error;
    logic [15:0] blk_wr_len;
    int n_fail = 0;
    int samples_checked = 0;

    // ========================================================================
    // Clock and instances
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    sbo_options_reg sbo_options_reg_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset),
        .ext_rd_req(ext_rd_req), .ext_rd_valid(ext_rd_valid), .ext_rd_data(ext_rd_data),
        .blk_wr_req(blk_wr_req), .blk_wr_len(blk_wr_len), .blk_wr_done(blk_wr_done),
        .ack_type_error(ack_type_error));
    sbo_node_model node_i (.pclk(pclk), .ext_rd_req(ext_rd_req),
        .ext_rd_valid(ext_rd_valid), .ext_rd_data(ext_rd_data), .blk_wr_req(blk_wr_req),
        .blk_wr_len(blk_wr_len), .blk_wr_done(blk_wr_done), .ack_type_error(ack_type_error));

    // ========================================================================
    // Checking helpers
    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A used-up wait ends the run at once
    task automatic lim(input bit ok);
        if (!ok) begin
            n_fail++;
            wrap_up();
        end
    endtask
    // Readable image after a full-word write; low request codes are refused
    function automatic logic [31:0] fold(input logic [31:0] w, input logic [31:0] o);
        fold = (w & 32'hF8FF_F0C0) | 32'h2;
        if (w[15:12] < 4'h8) begin
            fold[15:12] = o[15:12];
        end
    endfunction

    // ========================================================================
    // Bus and link tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        lim(k < 16);
    endtask
    // Software writes every field, generation included; request codes under 8 are refused
    task automatic wr_opt(input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, SBO_OPT_OFS, d, r, e);
        mdl = fold(d, mdl);
    endtask
    // Remote read first, so a fresh write must show with no other step
    task automatic cmp_opt(input int gap);
        logic [31:0] r, q;
        logic e;
        bit ok;
        node_i.rd_quad(gap, q, ok);
        lim(ok);
        chk(q, mdl);
        apb(1'b0, SBO_OPT_OFS, 32'h0, r, e);
        chk(r, mdl);
    endtask
    task automatic blk(input logic [15:0] len, input logic exp);
        logic err;
        bit ok;
        node_i.blk_wr(len, err, ok);
        lim(ok);
        chk({31'h0, err}, {31'h0, exp});
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic e;
        logic [3:0] codes[5];
        codes = '{4'h7, 4'h8, 4'h0, 4'hF, 4'h9};
        void'($urandom(78));
        mdl = 32'h0000_A002;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cmp_opt(0);
        apb(1'b0, SBO_CTRL_OFS, 32'h0, r, e);
        chk(r, 32'h1);
        wr_opt(32'hFFFF_FFFF);
        cmp_opt(0);
        foreach (codes[i]) begin
            wr_opt({16'h0, codes[i], 12'h0});
            cmp_opt(i);
        end
        repeat (24) begin
            wr_opt($urandom);
            cmp_opt($urandom_range(3));
        end
        // Software reset keeps only the request size
        wr_opt(32'hFFFF_FFFF);
        @(posedge pclk);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        mdl = 32'h0000_F002;
        cmp_opt(0);
        // Only byte lane 1 written: request code moves, other fields stay
        pstrb <= 4'h2;
        apb(1'b1, SBO_OPT_OFS, 32'hFFFF_9FFF, r, e);
        pstrb <= 4'hF;
        mdl = fold((mdl & 32'hFFFF_00FF) | 32'h0000_9F00, mdl);
        cmp_opt(2);
        // Length limits at 512 and 2048 bytes, then with the check off
        wr_opt(32'h0000_F000);
        blk(16'hFFFF, 1'b0);
        wr_opt(32'h0000_8000);
        blk(16'd512, 1'b0);
        blk(16'd513, 1'b1);
        wr_opt(32'h0000_A000);
        blk(16'd2048, 1'b0);
        blk(16'd2049, 1'b1);
        apb(1'b1, SBO_CTRL_OFS, 32'h0, r, e);
        blk(16'd2049, 1'b0);
        // Two refusals so far; clearing the sticky flag zeroes the count
        apb(1'b0, SBO_STAT_OFS, 32'h0, r, e);
        chk(r, 32'h0001_0002);
        apb(1'b1, SBO_STAT_OFS, 32'h0001_0000, r, e);
        apb(1'b0, SBO_STAT_OFS, 32'h0, r, e);
        chk(r, 32'h0);
        // Unmapped offset is refused and leaves the register alone
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk(r, 32'h0);
        cmp_opt(1);
        // Hardware reset in mid-run brings back the 2048-byte code
        wr_opt(32'hFFFF_FFFF);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        mdl = 32'h0000_A002;
        cmp_opt(0);
        apb(1'b0, SBO_CTRL_OFS, 32'h0, r, e);
        chk(r, 32'h1);
        wrap_up();
    end
endmodule
